// ===== core/tsc_consts.vh
/*
 * Constants of the touch sensor control register bank: register
 * addresses, write masks, reset values, field positions, pin function
 * codes and timing figures.
 * Assumes a 125 MHz system clock; included by bare name.
 */
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH

// clock rate
`define CLK_HZ            125000000
`define CLK_KHZ           125000
`define CLK_MHZ           125

// register addresses
`define A_CHAN_EN         8'h01
`define A_MODE_SLEEP      8'h05
`define A_SLAVE_ADDR      8'h06
`define A_LED_EN          8'h07
`define A_TOUCH           8'h2a
`define A_PAD_SPEED       8'h34
`define A_ROUTING         8'h35
`define A_IRQ_IR          8'h36
`define A_RST_CLK_DEB     8'h37
`define A_EXPIRY          8'h38
`define A_THRESH_FIRST    8'h39
`define A_THRESH_LAST     8'h40

// writable bits per register; reserved bits read as zero
`define M_MODE_SLEEP      8'h09
`define M_IRQ_IR          8'hf8
`define M_RST_CLK_DEB     8'h1e
`define M_THRESH          6'h3f

// reset values
`define R_CHAN_EN         8'hff
`define R_MODE_SLEEP      8'h00
`define R_SLAVE_ADDR      8'h48
`define R_LED_EN          8'h00
`define R_PAD_SPEED       8'h0a
`define R_ROUTING         8'h41
`define R_IRQ_IR          8'h10
`define R_RST_CLK_DEB     8'h0c
`define R_EXPIRY          8'h54
`define R_THRESH          6'h09

// field positions
`define F_BF              0
`define F_SLEEP           3
`define F_ADDR            7:1
`define F_CALIB_RATE      1:0
`define F_SER_CLK         4:2
`define F_PAD_IMP         5
`define F_DATA_PU         6
`define F_SYNC_PU         7
`define F_PAR_MODE        0
`define F_PAR_POL         1
`define F_PWM             2
`define F_P7_IR           3
`define F_P3_IRQ          4
`define F_SYNC_FN         6:5
`define F_A1_FN           7
`define F_LED_MODE        3
`define F_IR_WAIT         5:4
`define F_IRQ_MODE        6
`define F_A2_FN           7
`define F_SOFT_RESET_CMD          0
`define F_CLK_OFF         1
`define F_RESPONSE        4:2
`define F_STS_CLR         5
`define F_EXP_MODE        0
`define F_EXP_ON          1
`define F_EXP_TIME        5:2
`define F_MULTI           6
`define F_CAL_HOLD        7

// sync pin function codes
`define SYNC_UNUSED       2'b00
`define SYNC_REGULATOR    2'b01
`define SYNC_IRQ          2'b10
`define SYNC_IR_IN        2'b11

// timing figures
`define IR_WAIT_A_MS      90
`define IR_WAIT_B_MS      160
`define EXPIRY_UNIT_S     4
`define IRQ_PULSE_CYC     8'h7d   // 1 us of clk, sized for its counter

`endif

// ===== core/tsc_sync.v
/*
 * Two flip-flop synchroniser for a bundle of pin levels.
 * Assumes each bit is an independent slow level from another domain.
 */
`timescale 1ns/1ps
`default_nettype none
module tsc_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] asyncIn,
   output wire [W-1:0] syncOut
);
   reg [W-1:0] stage1_reg;
   reg [W-1:0] stage2_reg;

   // first stage feeds only the second
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= {W{1'b0}};
         stage2_reg <= {W{1'b0}};
      end else begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end
   assign syncOut = stage2_reg;
endmodule
`default_nettype wire

// ===== core/tsc_regs.v
/*
 * Register bank of an eight channel touch sensor behind a two-wire
 * serial slave port, with touch decision, output shaping, pin routing,
 * IR pause timing and output expiry.
 * Assumes scl/sda/reset/ir pins are asynchronous; touchRaw and
 * sampleTick come from sensing logic on clk.
 */
// What this block does
// - channel enables, disabled channel held reset
// - mode bit picks normal or baseline follow
// - sleep bit drives regulator control output
// - writable slave address, loaded from OTP
// - read-only touch result, one bit each
// - calibration rate field and global hold
// - three-bit serial clock rate selection
// - pad impedance and two pull-up enables
// - parallel outputs with selectable polarity
// - LED drive only with PWM, parallel off
// - port7 IR input, port3 interrupt choice
// - sync pin function field, reset interrupt
// - analog pins route interrupt or regulator
// - IR wait time and LED blanking
// - interrupt as pulse or level
// - clock stop bit and soft reset
// - touch after response plus one detections
// - status clear bit pulses clear
// - output expiry by four-second units
// - single or multi output operation
// - six-bit per channel threshold fields
// - auto increment address, ack every byte
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.vh"
module tsc_regs #(
   parameter [31:0] IR_WAIT_A_CYCLES = `IR_WAIT_A_MS * `CLK_KHZ,
   parameter [31:0] IR_WAIT_B_CYCLES = `IR_WAIT_B_MS * `CLK_KHZ,
   parameter [31:0] EXPIRY_UNIT_CYCLES = `EXPIRY_UNIT_S * `CLK_HZ
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        resetPin,
   input  wire        sclPin,
   input  wire        sdaPinIn,
   output wire        sdaPinOut,
   output reg         sdaPinOe,
   input  wire        sampleTick,
   input  wire [7:0]  touchRaw,
   input  wire        otpAddrValid,
   input  wire [6:0]  otpSlaveAddr,
   input  wire        port7In,
   input  wire        syncPinIn,
   output reg  [7:0]  parallelOut,
   output reg  [7:0]  parallelOe,
   output reg         syncPinOut,
   output reg         syncPinOe,
   output wire        analog1IrqSel,
   output wire        analog1Irq,
   output wire        analog2RegSel,
   output wire        analog2Regulator,
   output wire [7:0]  channelEnable,
   output wire        baselineFollow,
   output wire [1:0]  calibRate,
   output wire        calibHold,
   output wire [2:0]  serialClkSel,
   output wire        padLowImpedance,
   output wire        dataPinPullup,
   output wire        syncPinPullup,
   output wire        clockStop,
   output wire        softResetPulse,
   output wire        mtpStatusClear,
   output wire        sensingPause,
   output wire        ledPwmMode,
   output reg  [47:0] channelThresholds
);
   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_ADDR = 3'd1;
   localparam [2:0] S_ADDRACK = 3'd2;
   localparam [2:0] S_WR = 3'd3;
   localparam [2:0] S_WRACK = 3'd4;
   localparam [2:0] S_RD = 3'd5;
   localparam [2:0] S_RDACK = 3'd6;

   wire [4:0] pinSync;
   wire       rstPinS = pinSync[4];
   wire       sclS = pinSync[3];
   wire       sdaS = pinSync[2];
   wire       port7S = pinSync[1];
   wire       syncS = pinSync[0];

   reg [7:0]  chanEn_reg, modeSleep_reg, slaveAddr_reg, ledEn_reg;
   reg [7:0]  padSpeed_reg, routing_reg, irqIr_reg, rstClkDeb_reg;
   reg [7:0]  expiry_reg, touch_reg;
   reg [5:0]  thresh_reg [0:7];
   reg        swRst_reg, stsClr_reg, otpPending_reg;
   reg        sclD_reg, sdaD_reg, isRead_reg, idxPhase_reg, wrStb_reg;
   reg [2:0]  st_reg;
   reg [3:0]  bitCnt_reg;
   reg [7:0]  shift_reg, tx_reg, ptr_reg, wrAddr_reg, wrData_reg;
   reg [3:0]  deb_reg [0:7];
   reg [7:0]  det_reg, detPrev_reg;
   reg [31:0] unitCnt_reg, irWait_reg;
   reg [3:0]  units_reg;
   reg [7:0]  irqPulse_reg;
   reg [7:0]  parallelOutNext, parallelOeNext;
   reg        syncPinOutNext, syncPinOeNext;
   integer    i, j, k, m;

   tsc_sync #(.W(5)) pinSyncInst (
      .clk     (clk),
      .rst_n   (rst_n),
      .asyncIn ({resetPin, sclPin, sdaPinIn, port7In, syncPinIn}),
      .syncOut (pinSync)
   );

   // register read decode; unmapped addresses read zero
   function [7:0] readReg;
      input [7:0] a;
      begin
         case (a)
            `A_CHAN_EN:     readReg = chanEn_reg;
            `A_MODE_SLEEP:  readReg = modeSleep_reg;
            `A_SLAVE_ADDR:  readReg = slaveAddr_reg;
            `A_LED_EN:      readReg = ledEn_reg;
            `A_TOUCH:       readReg = touch_reg;
            `A_PAD_SPEED:   readReg = padSpeed_reg;
            `A_ROUTING:     readReg = routing_reg;
            `A_IRQ_IR:      readReg = irqIr_reg;
            `A_RST_CLK_DEB: readReg = rstClkDeb_reg;
            `A_EXPIRY:      readReg = expiry_reg;
            default: begin
               if (a >= `A_THRESH_FIRST && a <= `A_THRESH_LAST)
                  readReg = {2'b00, thresh_reg[a[2:0] - 3'd1]};
               else
                  readReg = 8'h00;
            end
         endcase
      end
   endfunction

   wire [7:0] rdByte = readReg(ptr_reg);
   wire       clrAll = swRst_reg | rstPinS;

   // bus edges from synchronised copies only
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclD_reg <= 1'b1;
         sdaD_reg <= 1'b1;
      end else begin
         sclD_reg <= sclS;
         sdaD_reg <= sdaS;
      end
   end
   wire sclRise = sclS & ~sclD_reg;
   wire sclFall = ~sclS & sclD_reg;
   wire startC = sclS & sclD_reg & sdaD_reg & ~sdaS;
   wire stopC = sclS & sclD_reg & ~sdaD_reg & sdaS;
   assign sdaPinOut = 1'b0;                      // open drain low only

   // serial slave: address, index byte on writes only, then streamed data
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= S_IDLE;
         bitCnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= 8'h00;
         isRead_reg <= 1'b0;
         idxPhase_reg <= 1'b0;
         wrStb_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
         wrData_reg <= 8'h00;
         sdaPinOe <= 1'b0;
      end else begin
         wrStb_reg <= 1'b0;
         if (startC) begin
            st_reg <= S_ADDR;
            bitCnt_reg <= 4'h0;
            sdaPinOe <= 1'b0;
         end else if (stopC) begin
            st_reg <= S_IDLE;
            sdaPinOe <= 1'b0;
         end else if (sclRise) begin
            if (st_reg == S_ADDR || st_reg == S_WR) begin
               shift_reg <= {shift_reg[6:0], sdaS};
               bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (st_reg == S_RDACK) begin
               ptr_reg <= ptr_reg + 8'h01;
               if (sdaS)
                  st_reg <= S_IDLE;              // master nack ends read
            end
         end else if (sclFall) begin
            case (st_reg)
               S_ADDR: if (bitCnt_reg == 4'h8) begin
                  if (shift_reg[7:1] == slaveAddr_reg[`F_ADDR]) begin
                     sdaPinOe <= 1'b1;
                     isRead_reg <= shift_reg[0];
                     st_reg <= S_ADDRACK;
                  end else
                     st_reg <= S_IDLE;
               end
               S_ADDRACK: if (isRead_reg) begin
                  tx_reg <= rdByte;
                  sdaPinOe <= ~rdByte[7];
                  bitCnt_reg <= 4'h1;
                  st_reg <= S_RD;
               end else begin
                  sdaPinOe <= 1'b0;
                  bitCnt_reg <= 4'h0;
                  idxPhase_reg <= 1'b1;
                  st_reg <= S_WR;
               end
               S_WR: if (bitCnt_reg == 4'h8) begin
                  sdaPinOe <= 1'b1;
                  st_reg <= S_WRACK;
                  if (idxPhase_reg) begin
                     ptr_reg <= shift_reg;
                     idxPhase_reg <= 1'b0;
                  end else begin
                     wrStb_reg <= 1'b1;
                     wrAddr_reg <= ptr_reg;
                     wrData_reg <= shift_reg;
                     ptr_reg <= ptr_reg + 8'h01;
                  end
               end
               S_WRACK: begin
                  sdaPinOe <= 1'b0;
                  bitCnt_reg <= 4'h0;
                  st_reg <= S_WR;
               end
               S_RD: if (bitCnt_reg == 4'h8) begin
                  sdaPinOe <= 1'b0;
                  st_reg <= S_RDACK;
               end else begin
                  sdaPinOe <= ~tx_reg[6];
                  tx_reg <= {tx_reg[6:0], 1'b0};
                  bitCnt_reg <= bitCnt_reg + 4'h1;
               end
               S_RDACK: begin
                  tx_reg <= rdByte;
                  sdaPinOe <= ~rdByte[7];
                  bitCnt_reg <= 4'h1;
                  st_reg <= S_RD;
               end
               default: st_reg <= S_IDLE;
            endcase
         end
      end
   end

   // register writes; pin or soft reset restores every value
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chanEn_reg <= `R_CHAN_EN;
         modeSleep_reg <= `R_MODE_SLEEP;
         slaveAddr_reg <= `R_SLAVE_ADDR;
         ledEn_reg <= `R_LED_EN;
         padSpeed_reg <= `R_PAD_SPEED;
         routing_reg <= `R_ROUTING;
         irqIr_reg <= `R_IRQ_IR;
         rstClkDeb_reg <= `R_RST_CLK_DEB;
         expiry_reg <= `R_EXPIRY;
         for (i = 0; i < 8; i = i + 1)
            thresh_reg[i] <= `R_THRESH;
         swRst_reg <= 1'b0;
         stsClr_reg <= 1'b0;
         otpPending_reg <= 1'b1;
      end else if (clrAll) begin
         chanEn_reg <= `R_CHAN_EN;
         modeSleep_reg <= `R_MODE_SLEEP;
         slaveAddr_reg <= `R_SLAVE_ADDR;
         ledEn_reg <= `R_LED_EN;
         padSpeed_reg <= `R_PAD_SPEED;
         routing_reg <= `R_ROUTING;
         irqIr_reg <= `R_IRQ_IR;
         rstClkDeb_reg <= `R_RST_CLK_DEB;
         expiry_reg <= `R_EXPIRY;
         for (i = 0; i < 8; i = i + 1)
            thresh_reg[i] <= `R_THRESH;
         swRst_reg <= 1'b0;
         stsClr_reg <= 1'b0;
         otpPending_reg <= 1'b1;
      end else begin
         stsClr_reg <= 1'b0;
         otpPending_reg <= 1'b0;
         // stored address comes from otp right after reset
         if (otpPending_reg && otpAddrValid)
            slaveAddr_reg <= {otpSlaveAddr, 1'b0};
         if (wrStb_reg) begin
            case (wrAddr_reg)
               `A_CHAN_EN:    chanEn_reg <= wrData_reg;
               `A_MODE_SLEEP: modeSleep_reg <= wrData_reg & `M_MODE_SLEEP;
               `A_SLAVE_ADDR: slaveAddr_reg <= wrData_reg;
               `A_LED_EN:     ledEn_reg <= wrData_reg;
               `A_PAD_SPEED:  padSpeed_reg <= wrData_reg;
               `A_ROUTING:    routing_reg <= wrData_reg;
               `A_IRQ_IR:     irqIr_reg <= wrData_reg & `M_IRQ_IR;
               `A_EXPIRY:     expiry_reg <= wrData_reg;
               `A_RST_CLK_DEB: begin
                  rstClkDeb_reg <= wrData_reg & `M_RST_CLK_DEB;
                  swRst_reg <= wrData_reg[`F_SOFT_RESET_CMD];
                  stsClr_reg <= wrData_reg[`F_STS_CLR];
               end
               default: begin
                  if (wrAddr_reg >= `A_THRESH_FIRST &&
                      wrAddr_reg <= `A_THRESH_LAST)
                     thresh_reg[wrAddr_reg[2:0] - 3'd1] <=
                        wrData_reg[5:0] & `M_THRESH;
               end
            endcase
         end
      end
   end

   // consecutive detections per channel; disabled channel held reset
   wire [3:0] debTarget = {1'b0, rstClkDeb_reg[`F_RESPONSE]} + 4'h1;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         det_reg <= 8'h00;
         for (j = 0; j < 8; j = j + 1)
            deb_reg[j] <= 4'h0;
      end else begin
         for (j = 0; j < 8; j = j + 1) begin
            if (!chanEn_reg[j] || clrAll) begin
               deb_reg[j] <= 4'h0;
               det_reg[j] <= 1'b0;
            end else if (sampleTick) begin
               if (!touchRaw[j]) begin
                  deb_reg[j] <= 4'h0;
                  det_reg[j] <= 1'b0;
               end else if (deb_reg[j] + 4'h1 >= debTarget)
                  det_reg[j] <= 1'b1;
               else
                  deb_reg[j] <= deb_reg[j] + 4'h1;
            end
         end
      end
   end

   // output expiry counts whole units while outputs stand unchanged (mode bit set) or while any output is on (mode bit clear)
   wire detChange = det_reg != detPrev_reg;
   wire expRestart = expiry_reg[`F_EXP_MODE] ? detChange : ~|det_reg;
   wire expired = expiry_reg[`F_EXP_ON] &&
                  units_reg >= expiry_reg[`F_EXP_TIME];
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         detPrev_reg <= 8'h00;
         unitCnt_reg <= 32'h0;
         units_reg <= 4'h0;
      end else begin
         detPrev_reg <= det_reg;
         if (!expiry_reg[`F_EXP_ON] || expRestart) begin
            unitCnt_reg <= 32'h0;
            units_reg <= 4'h0;
         end else if (!expired) begin
            if (unitCnt_reg == EXPIRY_UNIT_CYCLES - 32'h1) begin
               unitCnt_reg <= 32'h0;
               units_reg <= units_reg + 4'h1;
            end else
               unitCnt_reg <= unitCnt_reg + 32'h1;
         end
      end
   end

   // single mode keeps only the lowest touched channel
   wire [7:0] lowest = det_reg & (~det_reg + 8'h01);
   wire [7:0] shaped = expiry_reg[`F_MULTI] ? det_reg : lowest;
   wire [7:0] report = expired ? 8'h00 : shaped;
   wire       touchEvt = report != touch_reg;
   wire       irqSig = irqIr_reg[`F_IRQ_MODE] ? |touch_reg :
                       (irqPulse_reg != 8'h00);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         touch_reg <= 8'h00;
         irqPulse_reg <= 8'h00;
      end else begin
         touch_reg <= report;
         if (touchEvt)
            irqPulse_reg <= `IRQ_PULSE_CYC;
         else if (irqPulse_reg != 8'h00)
            irqPulse_reg <= irqPulse_reg - 8'h01;
      end
   end

   // ir input pauses sensing while high and for the wait time after
   wire irFromSync = routing_reg[`F_SYNC_FN] == `SYNC_IR_IN;
   wire irSelected = routing_reg[`F_P7_IR] | irFromSync;
   wire irLevel = routing_reg[`F_P7_IR] ? port7S : (irFromSync & syncS);
   wire [31:0] irWaitLoad = irqIr_reg[5] ? 32'h0 :
                            (irqIr_reg[4] ? IR_WAIT_B_CYCLES :
                             IR_WAIT_A_CYCLES);
   wire ledBlank = irqIr_reg[`F_LED_MODE] & irSelected & ~irLevel;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         irWait_reg <= 32'h0;
      else if (irLevel)
         irWait_reg <= irWaitLoad;
      else if (irWait_reg != 32'h0)
         irWait_reg <= irWait_reg - 32'h1;
   end
   assign sensingPause = irLevel | (irWait_reg != 32'h0);

   // pin routing for the parallel ports and the sync pin
   assign ledPwmMode = routing_reg[`F_PWM] & ~routing_reg[`F_PAR_MODE];
   always @* begin
      parallelOutNext = 8'h00;
      parallelOeNext = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
         if (routing_reg[`F_PAR_MODE]) begin
            parallelOutNext[k] = routing_reg[`F_PAR_POL] ?
                                 touch_reg[k] : ~touch_reg[k];
            parallelOeNext[k] = 1'b1;
         end else if (ledPwmMode) begin
            parallelOutNext[k] = ledEn_reg[k] & ~ledBlank;
            parallelOeNext[k] = 1'b1;
         end
      end
      if (routing_reg[`F_P3_IRQ]) begin
         parallelOutNext[3] = irqSig;
         parallelOeNext[3] = 1'b1;
      end
      if (routing_reg[`F_P7_IR]) begin
         parallelOutNext[7] = 1'b0;
         parallelOeNext[7] = 1'b0;
      end
      case (routing_reg[`F_SYNC_FN])
         `SYNC_REGULATOR: begin
            syncPinOutNext = modeSleep_reg[`F_SLEEP];
            syncPinOeNext = 1'b1;
         end
         `SYNC_IRQ: begin
            syncPinOutNext = irqSig;
            syncPinOeNext = 1'b1;
         end
         default: begin
            syncPinOutNext = 1'b0;
            syncPinOeNext = 1'b0;
         end
      endcase
   end

   // parallel and sync pin drivers come from flops so decode glitches never reach those pins
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         parallelOut <= 8'h00;
         parallelOe <= 8'h00;
         syncPinOut <= 1'b0;
         syncPinOe <= 1'b0;
      end else begin
         parallelOut <= parallelOutNext;
         parallelOe <= parallelOeNext;
         syncPinOut <= syncPinOutNext;
         syncPinOe <= syncPinOeNext;
      end
   end

   // flattened thresholds, channel 0 in the low bits
   always @* begin
      channelThresholds = 48'h0;
      for (m = 0; m < 8; m = m + 1)
         channelThresholds[m*6 +: 6] = thresh_reg[m];
   end

   // configuration and strobe outputs straight from the registers; analog1Irq also gated by the interrupt, analog2Regulator by the sleep bit
   assign channelEnable = chanEn_reg;
   assign baselineFollow = modeSleep_reg[`F_BF];
   assign calibRate = padSpeed_reg[`F_CALIB_RATE];
   assign calibHold = expiry_reg[`F_CAL_HOLD];
   assign serialClkSel = padSpeed_reg[`F_SER_CLK];
   assign padLowImpedance = padSpeed_reg[`F_PAD_IMP];
   assign dataPinPullup = padSpeed_reg[`F_DATA_PU];
   assign syncPinPullup = padSpeed_reg[`F_SYNC_PU];
   assign analog1IrqSel = routing_reg[`F_A1_FN];
   assign analog1Irq = routing_reg[`F_A1_FN] & irqSig;
   assign analog2RegSel = irqIr_reg[`F_A2_FN];
   assign analog2Regulator = irqIr_reg[`F_A2_FN] &
                             modeSleep_reg[`F_SLEEP];
   assign clockStop = rstClkDeb_reg[`F_CLK_OFF];
   assign softResetPulse = swRst_reg;
   assign mtpStatusClear = stsClr_reg;
endmodule
`default_nettype wire

// ===== testbench/tsc_checker.sv
/* port checker of the touch register bank.
   bound to tsc_regs from the bench top; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module tsc_checker (
   input wire logic        clk, rst_n, sclPin, sdaPinOut, sdaPinOe,
   input wire logic        clockStop, softResetPulse, mtpStatusClear,
   input wire logic        analog2Regulator,
   input wire logic [7:0]  channelEnable,
   input wire logic [1:0]  calibRate,
   input wire logic [2:0]  serialClkSel,
   input wire logic [47:0] channelThresholds
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // field values at the first edge after rst_n release
   en_reset_a: assert property (!$past(rst_n) |-> channelEnable == 8'hff)
      else $error("channel enables wrong after reset");
   rate_reset_a: assert property (!$past(rst_n) |-> calibRate == 2'h2 && serialClkSel == 3'h2)
      else $error("rate fields wrong after reset");
   thr_reset_a: assert property (!$past(rst_n) |-> channelThresholds == {8{6'h09}})
      else $error("thresholds wrong after reset");
   sleep_reset_a: assert property (!$past(rst_n) |-> !analog2Regulator && !clockStop)
      else $error("regulator or clock stop wrong after reset");
   // data pin is open drain: only ever pulled low
   sda_drive_a: assert property (sdaPinOut == 1'h0)
      else $error("data pin driven high");
   // the answer moves only while the clock pin is low, never on its rise
   ack_edge_a: assert property ($changed(sdaPinOe) |-> !$past(sclPin, 2))
      else $error("data drive changed outside clock low");
   soft_pulse_a: assert property (softResetPulse |=> !softResetPulse)
      else $error("soft reset longer than one cycle");
   soft_effect_a: assert property (softResetPulse |-> ##[1:3] (channelEnable == 8'hff && !clockStop))
      else $error("soft reset left fields unchanged");
   clr_pulse_a: assert property (mtpStatusClear |=> !mtpStatusClear)
      else $error("status clear longer than one cycle");
   cover property (softResetPulse);
   cover property (mtpStatusClear);
   cover property ($rose(sdaPinOe));
endmodule
`default_nettype wire

// ===== testbench/tsc_host.sv
/* host model: master on the two-wire port with a pull-up on data.
   assumes the device only pulls data low, through sdaPinOe. */
`timescale 1ns/1ps
`default_nettype none
module tsc_host (
   input  wire logic clk,
   output var logic  sclPin,
   output wire logic sdaPinIn,
   input  wire logic sdaPinOe
);
   logic       drv = 1'h1;
   logic [7:0] dev = 8'h48;
   // released line floats up; long low phase lets the slow answer settle
   assign sdaPinIn = drv & ~sdaPinOe;
   initial sclPin = 1'h1;
   task automatic bitx(input logic b, output logic s);
      drv = b;
      #24 sclPin = 1'h1;
      #16 s = sdaPinIn;
      #16 sclPin = 1'h0;
      #8;
   endtask
   task automatic go;
      @(posedge clk) #1 drv = 1'h1;   // every pin change lands just past an edge
      sclPin = 1'h1;
      #40 drv = 1'h0;
      #40 sclPin = 1'h0;
      #8;
   endtask
   task automatic stp;
      drv = 1'h0;
      #40 sclPin = 1'h1;
      #40 drv = 1'h1;
      #40;
   endtask
   // msb first, then the ninth bit with data released, read back low (ack) or high (nack)
   task automatic xf(input logic [7:0] v, output logic [7:0] q, output logic nk);
      for (int i = 7; i >= 0; i--) bitx(v[i], q[i]);
      bitx(1'h1, nk);
   endtask
   task automatic wr(input logic [7:0] a, d, output logic nk);
      logic [7:0] q;
      logic n1, n2, n3;
      go();
      xf(dev, q, n1);
      xf(a, q, n2);
      xf(d, q, n3);
      stp();
      nk = n1 | n2 | n3;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      logic n;
      go();
      xf(dev, q, n);
      xf(a, q, n);
      stp();
      go();
      xf(dev | 8'h01, q, n);
      xf(8'hff, q, n);
      stp();
   endtask
endmodule
`default_nettype wire

// ===== testbench/test_touch_sensor_control_regs.sv
/* bench top: register bank driven through the host model.
   assumes tsc_regs, tsc_host and tsc_checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_touch_sensor_control_regs;
   logic clk, rst_n, resetPin, sampleTick, otpAddrValid, port7In, syncPinIn, nk;
   logic [7:0] touchRaw, r;
   logic [6:0] otpSlaveAddr;
   wire sclPin, sdaPinIn, sdaPinOut, sdaPinOe, syncPinOut, syncPinOe, analog1IrqSel, analog1Irq, analog2RegSel;
   wire analog2Regulator, baselineFollow, calibHold, padLowImpedance, dataPinPullup, syncPinPullup;
   wire clockStop, softResetPulse, mtpStatusClear, sensingPause, ledPwmMode;
   wire [7:0] parallelOut, parallelOe, channelEnable;
   wire [1:0] calibRate;
   wire [2:0] serialClkSel;
   wire [47:0] channelThresholds;
   integer err_total = 0, samples_checked = 0, cyc = 0;
   logic [7:0] ra [13] = '{8'h01, 8'h05, 8'h06, 8'h07, 8'h2a, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h40, 8'h02};
   logic [7:0] rv [13] = '{8'hff, 8'h00, 8'h48, 8'h00, 8'h00, 8'h0a, 8'h41, 8'h10, 8'h0c, 8'h54, 8'h09, 8'h09, 8'h00};
   // short wait counts keep the pause and expiry timers in reach
   tsc_regs #(.IR_WAIT_A_CYCLES(50), .IR_WAIT_B_CYCLES(80), .EXPIRY_UNIT_CYCLES(200)) DUT (.*);
   tsc_host h (.*);
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // hang guard: the whole sequence needs well under 40000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic chk(input string n, input logic [47:0] s, e);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rchk(input logic [7:0] a, e);
      h.rd(a, r);
      chk($sformatf("register %h", a), r, e);
   endtask
   task automatic tick(input logic [7:0] t);
      @(posedge clk) #1 touchRaw = t;
      sampleTick = 1'h1;
      @(posedge clk) #1 sampleTick = 1'h0;
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      {rst_n, resetPin, sampleTick, touchRaw, otpAddrValid, port7In, syncPinIn} = '0;
      otpSlaveAddr = 7'h25;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'h1;
      repeat (5) @(posedge clk);
      foreach (ra[i]) rchk(ra[i], rv[i]);
      h.wr(8'h05, 8'h09, nk);
      chk("ack", nk, 1'h0);
      rchk(8'h05, 8'h09);
      h.wr(8'h36, 8'h90, nk);
      chk("mode", {baselineFollow, analog2Regulator, analog2RegSel}, 3'h7);
      // burst across all thresholds, index advancing each byte
      h.go();
      h.xf(8'h48, r, nk);
      h.xf(8'h39, r, nk);
      for (int i = 0; i < 8; i++) h.xf(8'(i), r, nk);
      h.stp();
      chk("thresholds", channelThresholds, {6'h7, 6'h6, 6'h5, 6'h4, 6'h3, 6'h2, 6'h1, 6'h0});
      rchk(8'h40, 8'h07);
      h.wr(8'h01, 8'h5a, nk);
      chk("enables", channelEnable, 8'h5a);
      repeat (3) tick(8'h03);
      rchk(8'h2a, 8'h00);
      tick(8'h03);
      repeat (3) @(posedge clk);
      chk("irq", syncPinOut, 1'h1);
      rchk(8'h2a, 8'h02);
      chk("irq", syncPinOut, 1'h0);
      chk("parallel", parallelOut[2:0], 3'h5);
      h.wr(8'h35, 8'h43, nk);
      chk("parallel", parallelOut[2:0], 3'h2);
      h.wr(8'h35, 8'h04, nk);
      chk("pwm", ledPwmMode, 1'h1);
      h.wr(8'h37, 8'h22, nk);
      chk("clock stop", clockStop, 1'h1);
      rchk(8'h37, 8'h02);
      h.wr(8'h37, 8'h01, nk);
      rchk(8'h01, 8'hff);
      @(posedge clk) #1 {otpAddrValid, resetPin} = 2'h3;
      repeat (6) @(posedge clk);
      #1 resetPin = 1'h0;
      repeat (5) @(posedge clk);
      h.wr(8'h01, 8'h00, nk);
      chk("old address", nk, 1'h1);
      h.dev = 8'h4a;
      rchk(8'h06, 8'h4a);
      end_of_test();
   end
endmodule
bind tsc_regs tsc_checker chk_i (.*);
`default_nettype wire
